// File: pkg/fabric_defs.svh
// Offsets, field positions, reset values and limits of the fabric block.
`ifndef FABRIC_DEFS_SVH
`define FABRIC_DEFS_SVH
`define ADDR_CTRL      12'h000
`define ADDR_LOCK      12'h004
`define ADDR_PROBE     12'h008
`define ADDR_STATUS    12'h00c
`define CTRL_KIND      0
`define CTRL_SCLK_LO   1
`define CTRL_INIT      3
`define CTRL_BYP_OUT   4
`define CTRL_BYP_IN    5
`define CTRL_FEEDBACK  6
`define CTRL_NET0_LO   7
`define CTRL_NET1_LO   9
`define CTRL_SLEW      11
`define CTRL_USE_BELOW 12
`define CTRL_WIDTH     13
`define CTRL_RESET     13'h0000
`define LOCK_ROLES     0
`define LOCK_PROBE     1
`define PROBE_WIDTH    3
`define PROBE_RESET    3'h0
`define PIN_COUNT      12
`define PIN_EXT_FIRST  0
`define PIN_EXT_SECOND 1
`define PIN_ARRAY_CLK  2
`define PIN_IO_CLK     3
`define PIN_INIT       4
`define PIN_MODE       5
`define PIN_PAD        6
`define PIN_PROBE      7
`define PIN_SERIAL     8
`define PIN_DIAG_CLK   9
`define PIN_GLOBAL_OE  10
`define PIN_GLOBAL_IE  11
`define DEDICATED_MAX_MHZ 200
`define ROUTED_MAX_MHZ    150
`endif

// File: pkg/fabric_pkg.sv
// Types shared by the fabric block.
package fabric_pkg;
   typedef enum logic [1:0] {
      SRC_PAD_FIRST   = 2'b00,
      SRC_PAD_SECOND  = 2'b01,
      SRC_INT_FIRST   = 2'b10,
      SRC_INT_SECOND  = 2'b11
   } clock_source_type;
   typedef enum logic [1:0] {
      SCLK_NET_ZERO = 2'b00,
      SCLK_NET_ONE  = 2'b01,
      SCLK_ARRAY    = 2'b10,
      SCLK_NONE     = 2'b11
   } storage_clock_type;
   typedef enum logic {
      KIND_FLOP  = 1'b0,
      KIND_LATCH = 1'b1
   } storage_kind_type;
   typedef enum logic {
      INIT_CLEAR  = 1'b0,
      INIT_PRESET = 1'b1
   } init_kind_type;
endpackage : fabric_pkg

// File: logic/cmodule_mux.sv
// Four-to-one logic module with gated select terms.
`timescale 1ns/1ps
module cmodule_mux (
   // Data inputs, index is the select pair
   input  wire logic [3:0] d,
   // Select terms
   input  wire logic       a0,
   input  wire logic       b0,
   input  wire logic       a1,
   input  wire logic       b1,
   // Result
   output logic            y
);
   logic s0;
   logic s1;
   assign s0 = a0 & b0;
   assign s1 = a1 | b1;
   assign y  = d[{s1, s0}];
endmodule : cmodule_mux

// File: logic/fabric_core.sv
// Logic, storage, pad register, pad driver, probe and clock network fabric.
// What this block does
// RULE1: Probe pin shows chosen node in diagnostic mode; the module stops this once the probe lock bit is set.
// RULE2: Module output selects by AND and OR terms.
// RULE3: One module realises five-input AND or OR; the module reaches four-input AND or OR at most.
// RULE4: Sequential module stores logic output, latch or flop.
// RULE5: Storage clock picked from three networks.
// RULE6: Storage clear comes from general routing.
// RULE7: Two pad registers on the pad clock.
// RULE8: Each pad register can be bypassed.
// RULE9: Separate data enables for both pad registers.
// RULE10: Global init net presets or clears per module.
// RULE11: Array output is pad or output register.
// RULE12: Side modules take above and below inputs.
// RULE13: Pad driver tri-states with four signals.
// RULE14: Global enables and slew only for test.
// RULE15: Temporary special pins are user pins otherwise.
// RULE16: Permanent pin roles fixed once locked.
// RULE17: Four clock networks, two dedicated, two routed.
// RULE18: Routed network source picked from four inputs.
// RULE19: Routed networks interchangeable, carry non-clock signals.
// RULE20: Register without data enable keeps value.
`timescale 1ns/1ps
`include "fabric_defs.svh"
module fabric_core import fabric_pkg::*; (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Clock pads and internal clock sources
   input  wire logic        external_clock_pad_first,
   input  wire logic        external_clock_pad_second,
   input  wire logic        array_clock_pad,
   input  wire logic        pad_register_clock,
   input  wire logic        internal_clock_source_first,
   input  wire logic        internal_clock_source_second,
   output logic             routed_clock_net_zero,
   output logic             routed_clock_net_one,
   // Diagnostic and temporary special pins
   input  wire logic        diag_mode_pin,
   input  wire logic        serial_data_pin,
   input  wire logic        diag_clock_pin,
   output logic             serial_data_user,
   output logic             diag_clock_user,
   input  wire logic        second_probe_in,
   output logic             second_probe_out,
   output logic             second_probe_oe,
   input  wire logic        probe_user_drive,
   input  wire logic        probe_user_oe,
   output logic             probe_user_sense,
   // Combinational module
   input  wire logic [3:0]  cm_data,
   input  wire logic [3:0]  cm_select,
   output logic             cm_y,
   // Sequential module
   input  wire logic [3:0]  sm_data,
   input  wire logic [3:0]  sm_select,
   input  wire logic        storage_clear_in,
   output logic             storage_q,
   // Pad register module
   input  wire logic        channel_input_above,
   input  wire logic        channel_input_below,
   input  wire logic        out_register_data_enable,
   input  wire logic        in_register_data_enable,
   input  wire logic        user_output_enable,
   input  wire logic        pad_sense_enable,
   input  wire logic        pad_register_init_net,
   output logic             io_y,
   // Pad pin and test controls
   input  wire logic        pad_pin_in,
   output logic             pad_pin_out,
   output logic             pad_pin_oe,
   output logic             pad_slew_fast,
   input  wire logic        global_drive_enable_test,
   input  wire logic        global_sense_enable_test
);
   logic [`PIN_COUNT-1:0]   pin_meta_reg;
   logic [`PIN_COUNT-1:0]   pin_sync_reg;
   logic [`PIN_COUNT-1:0]   pins;
   logic [`CTRL_WIDTH-1:0]  ctrl_reg;
   logic [1:0]              lock_reg;
   logic [`PROBE_WIDTH-1:0] probe_sel_reg;
   logic [31:0]             prdata_reg;
   logic                    storage_q_reg;
   logic                    out_reg;
   logic                    in_reg;
   logic                    sclk_prev_reg;
   logic                    pad_register_clock_prev_reg;
   logic                    probe_out_reg;
   logic                    probe_oe_reg;
   logic                    sm_y;
   logic                    sclk_level;
   logic                    sclk_rise;
   logic                    pad_register_clock_rise;
   logic                    mode;
   logic                    probe_active;
   logic                    probe_node;
   logic                    out_data;
   logic                    drive_en;
   logic                    sense_en;
   logic                    pad_drive_value;
   logic                    pad_sense_value;
   logic                    in_path;
   logic                    wr_en;
   logic                    addr_hit;
   storage_kind_type        kind;
   storage_clock_type       sclk_sel;
   init_kind_type           init_kind;
   clock_source_type        net0_src;
   clock_source_type        net1_src;

   // Pads pass two flip-flops before anything reads them; the internal clock sources do not.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= {global_sense_enable_test, global_drive_enable_test,
                          diag_clock_pin, serial_data_pin, second_probe_in,
                          pad_pin_in, diag_mode_pin, pad_register_init_net,
                          pad_register_clock, array_clock_pad,
                          external_clock_pad_second, external_clock_pad_first};
         pin_sync_reg <= pin_meta_reg;
      end
   end
   assign pins = pin_sync_reg;
   assign mode = pins[`PIN_MODE];

   assign kind      = storage_kind_type'(ctrl_reg[`CTRL_KIND]);
   assign sclk_sel  = storage_clock_type'(ctrl_reg[`CTRL_SCLK_LO +: 2]);
   assign init_kind = init_kind_type'(ctrl_reg[`CTRL_INIT]);
   assign net0_src  = clock_source_type'(ctrl_reg[`CTRL_NET0_LO +: 2]);
   assign net1_src  = clock_source_type'(ctrl_reg[`CTRL_NET1_LO +: 2]);

   // Both routed networks use one selector, so either can stand in for the other.
   function automatic logic net_source(input clock_source_type src,
                                       input logic [`PIN_COUNT-1:0] p,
                                       input logic int_a,
                                       input logic int_b);
      case (src)
         SRC_PAD_FIRST:  net_source = p[`PIN_EXT_FIRST];
         SRC_PAD_SECOND: net_source = p[`PIN_EXT_SECOND];
         SRC_INT_FIRST:  net_source = int_a;
         default:        net_source = int_b;
      endcase
   endfunction : net_source

   // RULE18 network source select
   assign routed_clock_net_zero = net_source(net0_src, pins,
                                  internal_clock_source_first,
                                  internal_clock_source_second);
   // RULE19 interchangeable routed network
   assign routed_clock_net_one  = net_source(net1_src, pins,
                                  internal_clock_source_first,
                                  internal_clock_source_second);

   // RULE2 select term mux
   // RULE3 wide gate form
   cmodule_mux u_cmod (
      .d  (cm_data),
      .a0 (cm_select[0]),
      .b0 (cm_select[1]),
      .a1 (cm_select[2]),
      .b1 (cm_select[3]),
      .y  (cm_y)
   );

   // RULE4 full logic module ahead of storage
   cmodule_mux u_smod (
      .d  (sm_data),
      .a0 (sm_select[0]),
      .b0 (sm_select[1]),
      .a1 (sm_select[2]),
      .b1 (sm_select[3]),
      .y  (sm_y)
   );

   // RULE5 storage clock select
   always_comb begin
      case (sclk_sel)
         SCLK_NET_ZERO: sclk_level = routed_clock_net_zero;
         SCLK_NET_ONE:  sclk_level = routed_clock_net_one;
         SCLK_ARRAY:    sclk_level = pins[`PIN_ARRAY_CLK];
         default:       sclk_level = 1'b0;
      endcase
   end

   // Edges are seen as level changes of the sampled clock; the fabric clocks
   // must therefore stay well below half the system rate.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_prev_reg  <= 1'b0;
         pad_register_clock_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg  <= sclk_level;
         pad_register_clock_prev_reg <= pins[`PIN_IO_CLK];
      end
   end
   assign sclk_rise  = sclk_level & ~sclk_prev_reg;
   // RULE17 dedicated pad register network
   assign pad_register_clock_rise = pins[`PIN_IO_CLK] & ~pad_register_clock_prev_reg;

   // RULE6 clear from routing
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         storage_q_reg <= 1'b0;
      end else if (storage_clear_in) begin
         storage_q_reg <= 1'b0;
      end else if (kind == KIND_LATCH ? sclk_level : sclk_rise) begin
         storage_q_reg <= sm_y;
      end
   end
   assign storage_q = storage_q_reg;

   // RULE12 above and below channel inputs
   assign out_data = ctrl_reg[`CTRL_USE_BELOW] ? channel_input_below : channel_input_above;

   // RULE14 test enables only in diagnostic mode
   assign drive_en = mode ? pins[`PIN_GLOBAL_OE] : user_output_enable;
   assign sense_en = mode ? pins[`PIN_GLOBAL_IE] : pad_sense_enable;
   // RULE13 sense path gated by input enable
   assign pad_sense_value = sense_en & pins[`PIN_PAD];

   // RULE7 output and input pad registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         out_reg <= 1'b0;
         in_reg  <= 1'b0;
      // RULE10 global preset or clear
      end else if (pins[`PIN_INIT]) begin
         out_reg <= (init_kind == INIT_PRESET);
         in_reg  <= (init_kind == INIT_PRESET);
      end else if (pad_register_clock_rise) begin
         // RULE9 separate data enables
         // RULE20 hold without enable
         if (out_register_data_enable) begin
            out_reg <= out_data;
         end
         if (in_register_data_enable) begin
            in_reg <= pad_sense_value;
         end
      end
   end

   // RULE8 register bypass
   assign pad_drive_value = ctrl_reg[`CTRL_BYP_OUT] ? out_data : out_reg;
   assign in_path         = ctrl_reg[`CTRL_BYP_IN] ? pad_sense_value : in_reg;
   // RULE11 feedback or pad to array
   assign io_y            = ctrl_reg[`CTRL_FEEDBACK] ? out_reg : in_path;

   // RULE13 tri-state pad driver
   assign pad_pin_out   = pad_drive_value;
   assign pad_pin_oe    = drive_en;
   assign pad_slew_fast = mode & ctrl_reg[`CTRL_SLEW];

   // RULE15 temporary pins are user pins when mode is low
   assign serial_data_user = mode ? 1'b0 : pins[`PIN_SERIAL];
   assign diag_clock_user  = mode ? 1'b0 : pins[`PIN_DIAG_CLK];

   // RULE1 probe mode select
   assign probe_active = mode & ~lock_reg[`LOCK_PROBE];
   always_comb begin
      case (probe_sel_reg)
         3'h0:    probe_node = cm_y;
         3'h1:    probe_node = storage_q_reg;
         3'h2:    probe_node = io_y;
         3'h3:    probe_node = out_reg;
         3'h4:    probe_node = in_reg;
         3'h5:    probe_node = routed_clock_net_zero;
         3'h6:    probe_node = routed_clock_net_one;
         default: probe_node = pad_sense_value;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         probe_out_reg <= 1'b0;
         probe_oe_reg  <= 1'b0;
      end else begin
         probe_out_reg <= probe_active ? probe_node : probe_user_drive;
         probe_oe_reg  <= probe_active | probe_user_oe;
      end
   end
   assign second_probe_out = probe_out_reg;
   assign second_probe_oe  = probe_oe_reg;
   assign probe_user_sense = probe_active ? 1'b0 : pins[`PIN_PROBE];

   // Register bus: zero wait states, error only on unmapped words.
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `ADDR_CTRL) || (a == `ADDR_LOCK) ||
                  (a == `ADDR_PROBE) || (a == `ADDR_STATUS);
   endfunction : is_mapped

   assign addr_hit = is_mapped(paddr);
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~addr_hit;
   assign wr_en    = psel & penable & pwrite & addr_hit;

   // RULE16 permanent roles frozen by lock
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (wr_en && paddr == `ADDR_CTRL) begin
         if (lock_reg[`LOCK_ROLES]) begin
            ctrl_reg <= {pwdata[`CTRL_WIDTH-1:`CTRL_SLEW],
                         ctrl_reg[`CTRL_SLEW-1:`CTRL_NET0_LO],
                         pwdata[`CTRL_FEEDBACK:`CTRL_BYP_OUT],
                         ctrl_reg[`CTRL_INIT],
                         pwdata[`CTRL_INIT-1:0]};
         end else begin
            ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
         end
      end
   end

   // Lock bits are set once; only reset clears them, so confidentiality holds.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         lock_reg <= 2'b00;
      end else if (wr_en && paddr == `ADDR_LOCK) begin
         lock_reg <= lock_reg | pwdata[1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         probe_sel_reg <= `PROBE_RESET;
      end else if (wr_en && paddr == `ADDR_PROBE) begin
         probe_sel_reg <= pwdata[`PROBE_WIDTH-1:0];
      end
   end

   // Read data is caught in the setup cycle and held through the access.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            `ADDR_CTRL:   prdata_reg <= {19'h0, ctrl_reg};
            `ADDR_LOCK:   prdata_reg <= {30'h0, lock_reg};
            `ADDR_PROBE:  prdata_reg <= {29'h0, probe_sel_reg};
            `ADDR_STATUS: prdata_reg <= {23'h0, pad_sense_value,
                                         routed_clock_net_one, routed_clock_net_zero,
                                         mode, cm_y, io_y, in_reg, out_reg,
                                         storage_q_reg};
            default:      prdata_reg <= 32'h0000_0000;
         endcase
      end
   end
   assign prdata = prdata_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence io_edge_s;
      pad_register_clock_rise && !pins[`PIN_INIT];
   endsequence

   probe_drive_a: assert property (probe_active |=> second_probe_oe &&
         second_probe_out == $past(probe_node)) // RULE1
      else $error("probe pin does not follow selected node");
   probe_user_a: assert property (!mode |=> second_probe_out == $past(probe_user_drive)) // RULE15
      else $error("probe pin not a user pin in normal mode");
   cmod_func_a: assert property (cm_y == ((cm_select[2] | cm_select[3]) ?
         ((cm_select[0] & cm_select[1]) ? cm_data[3] : cm_data[2]) :
         ((cm_select[0] & cm_select[1]) ? cm_data[1] : cm_data[0]))) // RULE2
      else $error("logic module selection wrong");
   wide_gate_a: assert property (cm_data == 4'b1000 |->
         cm_y == (&cm_select[1:0] & |cm_select[3:2])) // RULE3
      else $error("wide gate form wrong");
   flop_load_a: assert property (kind == KIND_FLOP && sclk_rise && !storage_clear_in
         |=> storage_q == $past(sm_y)) // RULE4
      else $error("storage flop missed a load");
   clock_pick_a: assert property (sclk_sel == SCLK_ARRAY |->
         sclk_level == pins[`PIN_ARRAY_CLK]) // RULE5
      else $error("storage clock not from array network");
   clear_wins_a: assert property (storage_clear_in |=> !storage_q) // RULE6
      else $error("storage clear ignored");
   io_load_a: assert property (io_edge_s and out_register_data_enable
         |=> out_reg == $past(out_data)) // RULE9
      else $error("output pad register missed a load");
   io_hold_a: assert property (io_edge_s and !out_register_data_enable
         |=> $stable(out_reg)) // RULE20
      else $error("output pad register changed without enable");
   init_net_a: assert property (pins[`PIN_INIT] |=>
         out_reg == ($past(init_kind) == INIT_PRESET)) // RULE10
      else $error("init net did not preset or clear");
   bypass_a: assert property (ctrl_reg[`CTRL_BYP_OUT] |-> pad_pin_out == out_data) // RULE8
      else $error("bypass path wrong");
   test_oe_a: assert property (!mode |-> pad_pin_oe == user_output_enable) // RULE14
      else $error("test enable leaked into normal mode");
   role_lock_a: assert property (lock_reg[`LOCK_ROLES] |=>
         $stable(ctrl_reg[`CTRL_SLEW-1:`CTRL_NET0_LO])) // RULE16
      else $error("locked clock role changed");
endmodule : fabric_core

// File: verif/pad_side_model.sv
// Outside world of one pad: the device driver, an outside driver and the pad's pull-down.
`timescale 1ns/1ps
module pad_side_model (
   // Device side of the pad
   input  wire logic dev_value,
   input  wire logic dev_enable,
   // Outside driver
   input  wire logic ext_value,
   input  wire logic ext_enable,
   // Level seen on the wire
   output logic      wire_level
);
   // tri-state wire resolution
   // An undriven pad reads low through its pull-down; two drivers at once give an unknown.
   assign wire_level = (dev_enable && ext_enable) ? 1'hx :
                       dev_enable ? dev_value : (ext_enable ? ext_value : 1'h0);
endmodule : pad_side_model

// File: verif/fabric_core_test.sv
// Self-checking bench driving the fabric block through its pins and register bus.
`timescale 1ns/1ps
`include "fabric_defs.svh"
module fabric_core_test import fabric_pkg::*; ();
   // Bus and clock sources: first pad, second pad, first internal, second internal
   logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  srcs, cm_data, cm_select, sm_data, sm_select;
   logic        array_clock_pad, pad_register_clock, routed_clock_net_zero, routed_clock_net_one;
   // Special pins
   logic        diag_mode_pin, serial_data_pin, diag_clock_pin, serial_data_user, diag_clock_user;
   logic        second_probe_in, second_probe_out, second_probe_oe;
   logic        probe_user_drive, probe_user_oe, probe_user_sense;
   // Logic, storage and pad register modules
   logic        cm_y, storage_clear_in, storage_q, channel_input_above, channel_input_below;
   logic        out_register_data_enable, in_register_data_enable, user_output_enable;
   logic        pad_sense_enable, pad_register_init_net, io_y;
   logic        pad_pin_in, pad_pin_out, pad_pin_oe, pad_slew_fast, ext_value, ext_enable;
   logic        global_drive_enable_test, global_sense_enable_test;
   int          fails, total_checks;

   fabric_core DUT (
      .clk_sys, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .external_clock_pad_first(srcs[0]), .external_clock_pad_second(srcs[1]),
      .internal_clock_source_first(srcs[2]), .internal_clock_source_second(srcs[3]),
      .array_clock_pad, .pad_register_clock, .routed_clock_net_zero, .routed_clock_net_one,
      .diag_mode_pin, .serial_data_pin, .diag_clock_pin, .serial_data_user, .diag_clock_user,
      .second_probe_in, .second_probe_out, .second_probe_oe, .probe_user_drive, .probe_user_oe,
      .probe_user_sense, .cm_data, .cm_select, .cm_y, .sm_data, .sm_select, .storage_clear_in,
      .storage_q, .channel_input_above, .channel_input_below, .out_register_data_enable,
      .in_register_data_enable, .user_output_enable, .pad_sense_enable, .pad_register_init_net,
      .io_y, .pad_pin_in, .pad_pin_out, .pad_pin_oe, .pad_slew_fast, .global_drive_enable_test,
      .global_sense_enable_test);
   pad_side_model pad_wire (.dev_value(pad_pin_out), .dev_enable(pad_pin_oe), .ext_value,
      .ext_enable, .wire_level(pad_pin_in));
   pad_side_model probe_wire (.dev_value(second_probe_out), .dev_enable(second_probe_oe),
      .ext_value, .ext_enable, .wire_level(second_probe_in));

   initial begin
      clk_sys = 1'h0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic final_report();
      if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'h1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'h1 && n < 16);
      if (n >= 16) begin
         fails++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // Pin clocks pass a two-flop synchroniser, so each level is held four cycles.
   task automatic pad_clock_pulse();
      pad_register_clock <= 1'h0;
      tick(4);
      pad_register_clock <= 1'h1;
      tick(4);
   endtask : pad_clock_pulse

   initial begin
      #40000;
      fails++;
      final_report();
   end

   initial begin
      {psel, penable, pwrite, rst_b, paddr, pwdata, srcs, cm_data, cm_select} = '0;
      {sm_data, sm_select, array_clock_pad, pad_register_clock, diag_mode_pin} = '0;
      {serial_data_pin, diag_clock_pin, probe_user_drive, probe_user_oe, storage_clear_in} = '0;
      {channel_input_above, channel_input_below, out_register_data_enable} = '0;
      {in_register_data_enable, user_output_enable, pad_sense_enable, pad_register_init_net} = '0;
      {ext_value, ext_enable, global_drive_enable_test, global_sense_enable_test} = '0;
      fails = 0;
      total_checks = 0;
      tick(6);
      rst_b <= 1'h1;
      for (int i = 0; i < 3; i++) begin
         apb(1'h0, 12'(4 * i), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'h0, 12'h010, 32'h0);
      chk(err, 1'h1);
      for (int i = 0; i < 256; i++) begin
         cm_data <= i[3:0];
         cm_select <= i[7:4];
         tick(1);
         chk(cm_y, i[{i[6] | i[7], i[4] & i[5]}]);
      end
      for (int s = 0; s < 4; s++) begin
         apb(1'h1, `ADDR_CTRL, (32'(s) << 7) | (32'(3 - s) << 9));
         srcs <= 4'h1 << s;
         tick(4);
         chk({routed_clock_net_one, routed_clock_net_zero}, 2'h1);
         srcs <= ~(4'h1 << s);
         tick(4);
         chk({routed_clock_net_one, routed_clock_net_zero}, 2'h2);
      end
      srcs <= 4'h0;
      sm_data <= 4'hf;
      apb(1'h1, `ADDR_CTRL, 32'h4);
      array_clock_pad <= 1'h1;
      tick(4);
      chk(storage_q, 1'h1);
      storage_clear_in <= 1'h1;
      tick(2);
      chk(storage_q, 1'h0);
      storage_clear_in <= 1'h0;
      array_clock_pad <= 1'h0;
      apb(1'h1, `ADDR_CTRL, 32'h100);
      srcs[2] <= 1'h1;
      tick(4);
      chk(storage_q, 1'h1);
      apb(1'h1, `ADDR_CTRL, 32'h5);
      array_clock_pad <= 1'h1;
      sm_data <= 4'h0;
      tick(4);
      chk(storage_q, 1'h0);
      array_clock_pad <= 1'h0;
      tick(4);
      sm_data <= 4'hf;
      tick(4);
      chk(storage_q, 1'h0);
      apb(1'h1, `ADDR_CTRL, 32'h40);
      channel_input_above <= 1'h1;
      out_register_data_enable <= 1'h1;
      pad_clock_pulse();
      chk(io_y, 1'h1);
      channel_input_above <= 1'h0;
      out_register_data_enable <= 1'h0;
      pad_clock_pulse();
      chk(io_y, 1'h1);
      apb(1'h1, `ADDR_CTRL, 32'h1040);
      channel_input_above <= 1'h1;
      out_register_data_enable <= 1'h1;
      pad_clock_pulse();
      chk(io_y, 1'h0);
      apb(1'h1, `ADDR_CTRL, 32'h1050);
      channel_input_below <= 1'h1;
      user_output_enable <= 1'h1;
      tick(2);
      chk({pad_pin_out, pad_pin_oe}, 2'h3);
      apb(1'h1, `ADDR_CTRL, 32'h0);
      {user_output_enable, ext_enable, ext_value} <= 3'h3;
      {pad_sense_enable, in_register_data_enable} <= 2'h3;
      pad_clock_pulse();
      chk(io_y, 1'h1);
      apb(1'h1, `ADDR_CTRL, 32'h20);
      ext_value <= 1'h0;
      tick(4);
      chk(io_y, 1'h0);
      for (int k = 1; k >= 0; k--) begin
         apb(1'h1, `ADDR_CTRL, 32'h40 | (32'(k) << 3));
         pad_register_init_net <= 1'h1;
         tick(4);
         apb(1'h0, `ADDR_STATUS, 32'h0);
         chk(rd[2:1], {2{k[0]}});
         pad_register_init_net <= 1'h0;
      end
      apb(1'h1, `ADDR_PROBE, 32'h0);
      apb(1'h1, `ADDR_CTRL, 32'h800);
      {ext_enable, cm_data, serial_data_pin, diag_clock_pin} <= 7'h3f;
      {global_drive_enable_test, diag_mode_pin} <= 2'h3;
      tick(4);
      chk({second_probe_out, second_probe_oe}, 2'h3);
      chk({serial_data_user, diag_clock_user, pad_slew_fast}, 3'h1);
      diag_mode_pin <= 1'h0;
      probe_user_oe <= 1'h1;
      tick(8);
      chk({second_probe_out, second_probe_oe, probe_user_sense}, 3'h2);
      chk({serial_data_user, diag_clock_user, pad_slew_fast}, 3'h6);
      apb(1'h1, `ADDR_CTRL, 32'hc8);
      apb(1'h1, `ADDR_LOCK, 32'h1);
      apb(1'h1, `ADDR_CTRL, 32'h0);
      apb(1'h0, `ADDR_CTRL, 32'h0);
      chk(rd, 32'h88);
      apb(1'h1, `ADDR_LOCK, 32'h2);
      chk(err, 1'h0);
      diag_mode_pin <= 1'h1;
      tick(4);
      chk({second_probe_out, second_probe_oe}, 2'h1);
      final_report();
   end
endmodule : fabric_core_test
